// ==== rtl/dual_timer.sv ====
// dual prescaled down-counter timer with plain register port
`timescale 1ns/1ps

module timer_unit (
    input  wire logic                          i_clk,        // core clock
    input  wire logic                          i_rst_n,      // synchronised reset
    input  wire logic                          i_wr_en,      // write to this timer
    input  wire logic [2:0]                    i_ofs,        // word offset
    input  wire logic [timer_pkg::DATA_W-1:0]  i_wdata,      // write data
    input  wire logic                          i_ext_clk,    // ext_timer_clock_in
    input  wire logic                          i_gate_in_n,  // gate_in_n
    output logic      [timer_pkg::DATA_W-1:0]  o_rdata,      // read mux
    output logic                               o_wave,       // timer_wave_out
    output logic                               o_irq,        // request level
    output logic      [timer_pkg::LVL_W-1:0]   o_level       // chosen level
);
    timer_pkg::timer_ctrl_t           ctrl_ff;
    logic [timer_pkg::CNT_W-1:0]      reload_ff;
    logic [timer_pkg::CNT_W-1:0]      match_ff;
    logic [timer_pkg::LVL_W-1:0]      level_ff;
    logic [timer_pkg::PRE_W-1:0]      pre_ff;
    logic [timer_pkg::CNT_W-1:0]      cnt_ff;
    logic [timer_pkg::CNT_W-1:0]      shadow_ff;
    logic [timer_pkg::NUM_FLAGS-1:0]  flags_ff;
    logic                             cmp_ff;
    logic                             wave_ff;
    logic                             irq_ff;
    logic                             load_pend_ff;
    logic                             half_ff;
    logic                             ext_m_ff;
    logic                             ext_s_ff;
    logic                             ext_d_ff;
    logic                             gate_m_ff;
    logic                             gate_s_ff;
    logic                             gate_d_ff;
    logic                             pre_d_ff;

    wire wr_ctrl   = i_wr_en && (i_ofs == timer_pkg::OFS_CTRL);
    wire wr_status = i_wr_en && (i_ofs == timer_pkg::OFS_STATUS);
    wire wr_reload = i_wr_en && (i_ofs == timer_pkg::OFS_RELOAD);
    wire wr_match  = i_wr_en && (i_ofs == timer_pkg::OFS_MATCH);
    wire wr_level  = i_wr_en && (i_ofs == timer_pkg::OFS_LEVEL);

    wire [timer_pkg::NUM_FLAGS-1:0] flag_clr =
        wr_status ? i_wdata[timer_pkg::NUM_FLAGS-1:0] : '0;

    wire capture_mode = (ctrl_ff.mode == timer_pkg::MODE_CAPTURE_COMPARE);
    wire gate_active  = ~gate_s_ff;
    // capture mode never gates the clock, the gate only sets the gate flag, which freezes the shadow
    wire gate_ok      = capture_mode || !ctrl_ff.gate_en || gate_active;
    wire armed        = ctrl_ff.run && ctrl_ff.pre_en;
    wire running      = armed && gate_ok;

    wire ext_fall  = ext_d_ff && !ext_s_ff;
    wire half_fall = half_ff;
    wire sel_fall  = ctrl_ff.clk_src_ext ? ext_fall : half_fall;
    wire pre_bit   = pre_ff[ctrl_ff.pre_tap];
    // tap 7 falls once per 256 selected ticks
    wire pre_fall  = pre_d_ff && !pre_bit;
    wire cnt_clk   = ctrl_ff.cnt_src_pre ? pre_fall : sel_fall;
    wire pre_tick  = running && sel_fall;
    wire cnt_tick  = running && cnt_clk;

    wire [timer_pkg::CNT_W-1:0] nxt_cnt =
        load_pend_ff ? reload_ff : cnt_ff - 16'h0001;
    wire timeout_ev = cnt_tick && (nxt_cnt == timer_pkg::CNT_RESET);
    wire match_ev   = cnt_tick && (nxt_cnt == match_ff);
    wire gate_rise  = gate_s_ff && !gate_d_ff;
    wire gate_ev    = ctrl_ff.run && ctrl_ff.gate_en && gate_rise;
    wire out_ev     = timeout_ev || (capture_mode && match_ev);

    wire [timer_pkg::NUM_FLAGS-1:0] set_vec = {gate_ev, match_ev, timeout_ev};
    // a set in the clearing cycle survives
    wire [timer_pkg::NUM_FLAGS-1:0] nxt_flags = (flags_ff & ~flag_clr) | set_vec;

    wire nxt_irq = |(nxt_flags & ctrl_ff.irq_enable_bits);

    logic nxt_wave;
    always_comb begin
        nxt_wave = wave_ff;
        if (!ctrl_ff.run) begin
            nxt_wave = 1'b0;
        end else if (out_ev) begin
            unique case (ctrl_ff.output_action_field)
                timer_pkg::ACT_HOLD:   nxt_wave = wave_ff;
                timer_pkg::ACT_TOGGLE: nxt_wave = ~wave_ff;
                timer_pkg::ACT_ZERO:   nxt_wave = 1'b0;
                timer_pkg::ACT_ONE:    nxt_wave = 1'b1;
            endcase
        end
    end

    timer_pkg::timer_status_t status;
    always_comb begin
        status          = '0;
        status.flags    = flags_ff;
        status.cmp      = cmp_ff;
        status.on       = running;
        status.gate_lvl = gate_s_ff;
        status.out_lvl  = wave_ff;
    end

    // read view of every register
    wire [timer_pkg::DATA_W-1:0] rd_ctrl   = ctrl_ff;
    wire [timer_pkg::DATA_W-1:0] rd_status = status;
    wire [timer_pkg::DATA_W-1:0] rd_level  = {13'h0000, level_ff};
    assign o_rdata =
        (i_ofs == timer_pkg::OFS_CTRL)   ? rd_ctrl   :
        (i_ofs == timer_pkg::OFS_STATUS) ? rd_status :
        (i_ofs == timer_pkg::OFS_RELOAD) ? reload_ff :
        (i_ofs == timer_pkg::OFS_MATCH)  ? match_ff  :
        (i_ofs == timer_pkg::OFS_COUNT)  ? shadow_ff :
        (i_ofs == timer_pkg::OFS_LEVEL)  ? rd_level  : 16'h0000;

    assign o_wave  = wave_ff;
    assign o_irq   = irq_ff;
    assign o_level = level_ff;

    // software registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff   <= timer_pkg::CTRL_RESET;
            reload_ff <= timer_pkg::RELOAD_RESET;
            match_ff  <= timer_pkg::MATCH_RESET;
            level_ff  <= timer_pkg::LEVEL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= i_wdata;
            end
            if (wr_reload) begin
                reload_ff <= i_wdata;
            end
            if (wr_match) begin
                match_ff <= i_wdata;
            end
            if (wr_level) begin
                level_ff <= i_wdata[timer_pkg::LVL_W-1:0];
            end
        end
    end

    // input synchronisers and half-rate tick, levels must be held a full period by the driver
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_m_ff  <= 1'b0;
            ext_s_ff  <= 1'b0;
            ext_d_ff  <= 1'b0;
            gate_m_ff <= 1'b1;
            gate_s_ff <= 1'b1;
            gate_d_ff <= 1'b1;
            half_ff   <= 1'b0;
        end else begin
            ext_m_ff  <= i_ext_clk;
            ext_s_ff  <= ext_m_ff;
            ext_d_ff  <= ext_s_ff;
            gate_m_ff <= i_gate_in_n;
            gate_s_ff <= gate_m_ff;
            gate_d_ff <= gate_s_ff;
            half_ff   <= ~half_ff;
        end
    end

    // prescaler
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_ff   <= timer_pkg::PRE_RESET;
            pre_d_ff <= 1'b1;
        end else begin
            if (!armed) begin
                pre_ff <= timer_pkg::PRE_RESET;
            end else if (pre_tick) begin
                pre_ff <= pre_ff - 8'h01;
            end
            pre_d_ff <= pre_bit;
        end
    end

    // counter, pending load covers both the first tick and post-timeout tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff       <= timer_pkg::CNT_RESET;
            load_pend_ff <= 1'b1;
        end else if (!armed) begin
            cnt_ff       <= timer_pkg::CNT_RESET;
            load_pend_ff <= 1'b1;
        end else if (cnt_tick) begin
            cnt_ff       <= nxt_cnt;
            load_pend_ff <= timeout_ev;
        end
    end

    // status, shadow, output and request
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_ff  <= '0;
            cmp_ff    <= 1'b0;
            shadow_ff <= timer_pkg::CNT_RESET;
            wave_ff   <= 1'b0;
            irq_ff    <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            // timeout wins when the match value is zero
            if (timeout_ev) begin
                cmp_ff <= 1'b0;
            end else if (match_ev) begin
                cmp_ff <= 1'b1;
            end
            // a pending gate event freezes the captured count
            if (!flags_ff[timer_pkg::FLAG_GATE]) begin
                shadow_ff <= cnt_ff;
            end
            wave_ff <= nxt_wave;
            irq_ff  <= nxt_irq;
        end
    end
endmodule

module dual_timer (
    input  wire logic                              i_core_clk,  // 125 MHz core clock
    input  wire logic                              i_reset_n,   // async reset, low
    input  wire logic [timer_pkg::ADDR_W-1:0]      i_addr,      // word address
    input  wire logic [timer_pkg::DATA_W-1:0]      i_wdata,     // write data
    input  wire logic                              i_wr,        // write strobe
    input  wire logic                              i_rd,        // read strobe
    input  wire logic [timer_pkg::NUM_TIMERS-1:0]  i_ext_clk,   // ext_timer_clock_in
    input  wire logic [timer_pkg::NUM_TIMERS-1:0]  i_gate_n,    // gate_in_n
    output logic      [timer_pkg::DATA_W-1:0]      o_rdata,     // read data
    output logic      [timer_pkg::NUM_TIMERS-1:0]  o_wave,      // timer_wave_out
    output logic      [timer_pkg::NUM_LEVELS-1:0]  o_irq_level  // irq_level_outputs
);
    logic                                 rst_m_ff;
    logic                                 rst_n_ff;
    logic [timer_pkg::DATA_W-1:0]         rdata_ff;
    logic [timer_pkg::NUM_TIMERS-1:0]     wave_ff;
    logic [timer_pkg::NUM_LEVELS-1:0]     irq_lvl_ff;
    logic [timer_pkg::DATA_W-1:0]         t_rdata [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::NUM_TIMERS-1:0]     t_wave;
    logic [timer_pkg::NUM_TIMERS-1:0]     t_irq;
    logic [timer_pkg::LVL_W-1:0]          t_level [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::NUM_LEVELS-1:0]     nxt_irq_lvl;

    wire       sel = i_addr[timer_pkg::SEL_BIT];
    wire [2:0] ofs = i_addr[2:0];
    wire [timer_pkg::DATA_W-1:0] nxt_rdata = i_rd ? t_rdata[sel] : 16'h0000;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_m_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_m_ff <= 1'b1;
            rst_n_ff <= rst_m_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < timer_pkg::NUM_TIMERS; g++) begin : g_timer
            timer_unit u_timer (
                .i_clk       (i_core_clk),
                .i_rst_n     (rst_n_ff),
                .i_wr_en     (i_wr && (sel == 1'(g))),
                .i_ofs       (ofs),
                .i_wdata     (i_wdata),
                .i_ext_clk   (i_ext_clk[g]),
                .i_gate_in_n (i_gate_n[g]),
                .o_rdata     (t_rdata[g]),
                .o_wave      (t_wave[g]),
                .o_irq       (t_irq[g]),
                .o_level     (t_level[g])
            );
        end
    endgenerate

    // level zero means the timer requests nothing
    always_comb begin
        nxt_irq_lvl = '0;
        for (int l = 0; l < timer_pkg::NUM_LEVELS; l++) begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++) begin
                if (t_irq[t] && (t_level[t] == 3'(l + 1))) begin
                    nxt_irq_lvl[l] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff   <= 16'h0000;
            wave_ff    <= '0;
            irq_lvl_ff <= '0;
        end else begin
            rdata_ff   <= nxt_rdata;
            wave_ff    <= t_wave;
            irq_lvl_ff <= nxt_irq_lvl;
        end
    end

    assign o_rdata     = rdata_ff;
    assign o_wave      = wave_ff;
    assign o_irq_level = irq_lvl_ff;
endmodule

// ==== pkg/timer_pkg.sv ====
// shared constants, field layouts and types of the dual prescaled timer
package timer_pkg;

    localparam int NUM_TIMERS = 2;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 16;
    localparam int PRE_W      = 8;
    localparam int CNT_W      = 16;
    localparam int LVL_W      = 3;
    localparam int NUM_LEVELS = 7;
    localparam int SEL_BIT    = 3;

    // word offsets inside one timer's window
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_STATUS = 3'h1;
    localparam logic [2:0] OFS_RELOAD = 3'h2;
    localparam logic [2:0] OFS_MATCH  = 3'h3;
    localparam logic [2:0] OFS_COUNT  = 3'h4;
    localparam logic [2:0] OFS_LEVEL  = 3'h5;

    // status flag positions that software clears by writing one
    localparam int FLAG_TIMEOUT = 0;
    localparam int FLAG_MATCH   = 1;
    localparam int FLAG_GATE    = 2;
    localparam int NUM_FLAGS    = 3;

    localparam logic [PRE_W-1:0]  PRE_RESET    = 8'hFF;
    localparam logic [CNT_W-1:0]  CNT_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;
    localparam logic [CNT_W-1:0]  RELOAD_RESET = 16'h0000;
    localparam logic [CNT_W-1:0]  MATCH_RESET  = 16'h0000;
    localparam logic [LVL_W-1:0]  LEVEL_RESET  = 3'h0;

    typedef enum logic [2:0] {
        MODE_CAPTURE_COMPARE = 3'b000,
        MODE_SQUARE_WAVE     = 3'b001,
        MODE_VAR_DUTY        = 3'b010,
        MODE_SINGLE_SHOT     = 3'b011,
        MODE_PULSE_WIDTH     = 3'b100,
        MODE_PERIOD          = 3'b101,
        MODE_EVENT_COUNT     = 3'b110,
        MODE_SPARE           = 3'b111
    } mode_t;

    typedef enum logic [1:0] {
        ACT_HOLD   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_ZERO   = 2'b10,
        ACT_ONE    = 2'b11
    } out_act_t;

    typedef struct packed {
        logic [NUM_FLAGS-1:0] irq_enable_bits;
        out_act_t             output_action_field;
        logic                 gate_en;
        mode_t                mode;
        logic [2:0]           pre_tap;
        logic                 cnt_src_pre;
        logic                 clk_src_ext;
        logic                 pre_en;
        logic                 run;
    } timer_ctrl_t;

    typedef struct packed {
        logic [8:0]           rsvd;
        logic                 out_lvl;
        logic                 gate_lvl;
        logic                 on;
        logic                 cmp;
        logic [NUM_FLAGS-1:0] flags;
    } timer_status_t;

endpackage

// ==== sim/dual_timer_properties.sv ====
// port assertions and covers for the dual timer
`timescale 1ns/1ps
module dual_timer_properties (
    input wire logic [0:0]                       i_core_clk,  // clock
    input wire logic [0:0]                       i_reset_n,   // async reset
    input wire logic [timer_pkg::ADDR_W-1:0]     i_addr,      // address
    input wire logic [timer_pkg::DATA_W-1:0]     i_wdata,     // write data
    input wire logic [0:0]                       i_wr,        // write strobe
    input wire logic [0:0]                       i_rd,        // read strobe
    input wire logic [timer_pkg::NUM_TIMERS-1:0] i_ext_clk,   // external clocks
    input wire logic [timer_pkg::NUM_TIMERS-1:0] i_gate_n,    // gates
    input wire logic [timer_pkg::DATA_W-1:0]     o_rdata,     // read data
    input wire logic [timer_pkg::NUM_TIMERS-1:0] o_wave,      // wave outputs
    input wire logic [timer_pkg::NUM_LEVELS-1:0] o_irq_level  // request levels
);
    logic wr_seen_ff;

    // nothing can run before software has written once
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_seen_ff <= 1'b0;
        end else if (i_wr) begin
            wr_seen_ff <= 1'b1;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (i_rd && i_addr[2:1] == 2'b11 |=> o_rdata == '0)
        else $error("unmapped offset read not zero");
    AST_READBACK: assert property (i_wr && i_addr[2:1] == 2'b01 ##1
        i_rd && i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2))
        else $error("reload or match readback differs");
    AST_STATUS_RSVD: assert property (i_rd && i_addr[2:0] == 3'h1 |=> o_rdata[15:7] == '0)
        else $error("status reserved bits set");
    AST_IDLE_OUT: assert property (!wr_seen_ff |-> o_wave == '0 && o_irq_level == '0)
        else $error("outputs active before any setup");
    AST_COUNT_RESET: assert property (i_rd && i_addr[2:0] == 3'h4 && !wr_seen_ff
        |=> o_rdata == '0)
        else $error("counter not zero after reset");
    AST_GATE_LVL: assert property ($stable(i_gate_n[0]) [*4] ##0
        (i_rd && i_addr == 4'h1) |=> o_rdata[5] == $past(i_gate_n[0]))
        else $error("gate level bit wrong");
    AST_IRQ_TWO: assert property ($countones(o_irq_level) <= 2)
        else $error("more request levels than timers");
    AST_WAVE_STEP: assert property ($changed(o_wave[0]) |=> $stable(o_wave[0]))
        else $error("wave changed on adjacent cycles");

    COV_STATUS_READ: cover property (i_rd && i_addr[2:0] == 3'h1);
    COV_IRQ: cover property (o_irq_level != '0);
    COV_WAVE: cover property ($rose(o_wave[1]));
endmodule

bind dual_timer dual_timer_properties u_props (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk),
    .i_gate_n(i_gate_n), .o_rdata(o_rdata), .o_wave(o_wave),
    .o_irq_level(o_irq_level)
);

// ==== sim/ext_pin_source.sv ====
// far-side pin source: external timer clock and gate levels
`timescale 1ns/1ps
module ext_pin_source (
    input  wire logic       i_clk,      // core clock
    input  wire logic [1:0] i_gate_hi,  // requested gate negation
    output logic      [1:0] o_ext_clk,  // ext_timer_clock_in per timer
    output logic      [1:0] o_gate_n    // gate_in_n per timer
);
    logic [2:0] div_ff  = 3'h0;
    logic [1:0] gate_ff = 2'h0;

    // levels change only at core edges, so each lasts whole periods
    always @(posedge i_clk) begin
        div_ff  <= div_ff + 3'h1;
        gate_ff <= i_gate_hi;
    end
    assign o_ext_clk = {2{div_ff[2]}};
    assign o_gate_n  = gate_ff;
endmodule

// ==== sim/dual_timer_test.sv ====
// self-checking bench for the dual timer
`timescale 1ns/1ps
module dual_timer_test;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } reg_row_t;
    typedef struct packed {
        logic [3:0]  base;
        logic [15:0] ctrl;
        logic [15:0] reload;
        logic [15:0] match;
        logic [15:0] period;
    } wave_row_t;
    logic        i_core_clk  = 1'b0;
    logic        i_reset_n   = 1'b0;
    logic [3:0]  i_addr      = 4'h0;
    logic [15:0] i_wdata     = 16'h0000;
    logic        i_wr        = 1'b0;
    logic        i_rd        = 1'b0;
    logic [1:0]  gate_hi     = 2'h0;
    logic [1:0]  i_ext_clk;
    logic [1:0]  i_gate_n;
    logic [15:0] o_rdata;
    logic [1:0]  o_wave;
    logic [6:0]  o_irq_level;
    logic [15:0] got;
    logic        w;
    int          failures    = 0;
    int          check_count = 0;
    int          n;
    reg_row_t    regs [8]    = '{'{4'h2, 16'hA5C3, 16'hA5C3}, '{4'h3, 16'h0FF0, 16'h0FF0},
        '{4'h5, 16'hFFFD, 16'h0005}, '{4'hA, 16'h5A3C, 16'h5A3C},
        '{4'hD, 16'h0002, 16'h0002}, '{4'h6, 16'hFFFF, 16'h0000},
        '{4'hC, 16'h1234, 16'h0000}, '{4'h1, 16'h0000, 16'h0000}};
    // half clock, ext clock, prescaler tap 0 and tap 7
    wave_row_t   waves [5]   = '{'{4'h0, 16'h0803, 16'h7, 16'h4, 16'h8},
        '{4'h0, 16'h0883, 16'h7, 16'h4, 16'h10}, '{4'h8, 16'h0887, 16'h2, 16'h0, 16'h18},
        '{4'h0, 16'h088B, 16'h1, 16'h0, 16'h8}, '{4'h0, 16'h08FB, 16'h1, 16'h0, 16'h400}};

    dual_timer u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk),
        .i_gate_n(i_gate_n), .o_rdata(o_rdata), .o_wave(o_wave), .o_irq_level(o_irq_level));
    ext_pin_source u_pins (.i_clk(i_core_clk), .i_gate_hi(gate_hi), .o_ext_clk(i_ext_clk),
        .o_gate_n(i_gate_n));

    always #4 i_core_clk = ~i_core_clk;

    task automatic results();
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic op(input logic wv, input logic rv, input logic [3:0] a,
                      input logic [15:0] d);
        i_wr <= wv;
        i_rd <= rv;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, a, d);
    endtask

    // data is taken at the edge after the read, before it drops
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, a, 16'h0000);
        d = o_rdata;
    endtask

    task automatic edge_wait(input int t, output int cnt);
        logic w0;
        w0 = o_wave[t];
        for (cnt = 1; cnt < 3000; cnt++) begin
            @(posedge i_core_clk);
            if (o_wave[t] !== w0) return;
        end
        failures++;
        results();
    endtask

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rd(4'h4, got);
        chk("count after reset", got, 16'h0000);
        foreach (regs[k]) begin
            op(1'b1, 1'b0, regs[k].addr, regs[k].wdata);
            rd(regs[k].addr, got);
            chk("register", got, regs[k].exp);
        end
        foreach (waves[k]) begin
            wr(waves[k].base | 4'h2, waves[k].reload);
            wr(waves[k].base | 4'h3, waves[k].match);
            wr(waves[k].base, waves[k].ctrl);
            edge_wait(int'(waves[k].base[3]), n);
            edge_wait(int'(waves[k].base[3]), n);
            chk("wave period", 16'(n), waves[k].period);
            wr(waves[k].base, 16'h0000);
        end
        wr(4'h1, 16'h0007);
        wr(4'h0, 16'h2883);
        edge_wait(0, n);
        repeat (6) @(posedge i_core_clk);
        chk("irq level", {9'h000, o_irq_level}, 16'h0010);
        wr(4'h0, 16'h2880);
        rd(4'h1, got);
        chk("flags", got & 16'h0007, 16'h0003);
        wr(4'h1, 16'h0007);
        repeat (3) @(posedge i_core_clk);
        chk("irq dropped", {9'h000, o_irq_level}, 16'h0000);
        wr(4'h0, 16'h0883);
        edge_wait(0, n);
        repeat (6) @(posedge i_core_clk);
        chk("irq masked", {9'h000, o_irq_level}, 16'h0000);
        rd(4'h1, got);
        chk("status on", got & 16'h0011, 16'h0011);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0007);
        wr(4'h0, 16'h0C83);
        edge_wait(0, n);
        gate_hi <= 2'h1;
        repeat (8) @(posedge i_core_clk);
        w = o_wave[0];
        repeat (48) @(posedge i_core_clk);
        chk("gated wave", {15'h0000, o_wave[0]}, {15'h0000, w});
        rd(4'h1, got);
        chk("gate flag", got & 16'h0024, 16'h0024);
        wr(4'h1, 16'h0004);
        rd(4'h1, got);
        chk("gate cleared", got & 16'h0004, 16'h0000);
        gate_hi <= 2'h0;
        // stop before reprogramming, ctrl must not change while running
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0883);
        repeat (20) @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        chk("wave in reset", {14'h0000, o_wave}, 16'h0000);
        rd(4'h0, got);
        chk("ctrl reset", got, 16'h0000);
        rd(4'h4, got);
        chk("count reset", got, 16'h0000);
        results();
    end
endmodule
